// file: core/beam_command_process_objects.sv
// command interpreter, teach status and process-data objects of a light curtain
`timescale 1ns/1ps
`default_nettype none
`include "beam_cmd_map.svh"

module beam_command_process_objects #(
  parameter int unsigned SAVE_CYCLES = `SAVE_CYCLES  // save window, shorten in sim
) (
  input  wire logic                   ref_clk,
  input  wire logic                   rst_n,
  // register port
  input  wire logic [`ADDR_W-1:0]     regAddr,
  input  wire logic [15:0]            writeData,
  input  wire logic                   writeStrobe,
  input  wire logic                   readStrobe,
  output logic      [15:0]            readData,
  // measurement side
  input  wire logic                   measStrobe,
  input  wire logic [`NUM_BEAMS-1:0]  beamBlocked,
  input  wire logic [15:0]            levelFirstIn,
  input  wire logic [15:0]            levelLastIn,
  input  wire logic [3:0]             digitalIn,
  input  wire logic                   statusChange,
  // command side
  input  wire logic                   teachDone,
  input  wire logic                   teachFail,
  input  wire logic                   saveDone,
  output logic                        teachStart,
  output logic                        rebootReq,
  output logic                        eraseReq,
  output logic                        saveStart,
  output logic                        saveBusy,
  output logic                        splitBusy,
  output logic      [3:0]             switchOut
);

  // ============================================================
  // helpers
  // address match on {index, sub}
  function automatic logic hit(input logic [`ADDR_W-1:0] a, input logic [15:0] idx,
                               input logic [7:0] sub);
    hit = (a == {idx, sub});
  endfunction : hit

  // ============================================================
  // state
  beam_cmd_pkg::state_t state;                 // sequencer state
  beam_cmd_pkg::state_t next_state;            // its next value
  logic [15:0]  cmdParam;                      // last written argument
  logic [5:0]   areaCount;                     // areas in force, 1..32
  logic         allMode;                       // 1: area needs all beams blocked
  logic [4:0]   areaOfBeam [`NUM_BEAMS];       // owning area of each beam
  logic [6:0]   areaFirst  [`MAX_AREAS];       // first beam number of area
  logic [6:0]   areaLast   [`MAX_AREAS];       // last beam number of area
  logic [6:0]   walkBeam;                      // split walk position
  logic [7:0]   walkAcc;                       // fractional accumulator
  logic [4:0]   walkArea;                      // area being filled
  logic         walkNew;                       // walk position opens an area
  logic [31:0]  saveCount;                     // cycles spent saving
  logic [7:0]   teachStatus;                   // teach result byte
  logic         teachRunning;                  // teach in flight
  logic [15:0]  levelFirst;                    // latched first-beam level
  logic [15:0]  levelLast;                     // latched last-beam level
  logic [15:0]  firstBlocked;                  // process data, latched
  logic [15:0]  firstClear;
  logic [15:0]  lastBlocked;
  logic [15:0]  lastClear;
  logic [15:0]  blockedTotal;
  logic [15:0]  clearTotal;
  logic [31:0]  areaRes;                       // area results, bit k = area k+1
  logic [11:0]  cycleNum;                      // measurement cycle counter
  logic         eventFlag;                     // sticky status-change flag
  logic         validFlag;                     // a measurement exists

  // ============================================================
  // write decode
  wire writeOk    = writeStrobe && (state != beam_cmd_pkg::ST_SAVE);
  wire wrParam    = writeOk && hit(regAddr, `IDX_CMD, `SUB_CMD_PARAM);
  wire wrCode     = writeOk && hit(regAddr, `IDX_CMD, `SUB_CMD_CODE);
  wire cmdIdle    = (state == beam_cmd_pkg::ST_IDLE);
  // commands only start from idle; split walk is short
  wire goTeach    = wrCode && cmdIdle && (writeData == beam_cmd_pkg::CMD_TEACH);
  wire goReboot   = wrCode && cmdIdle && (writeData == beam_cmd_pkg::CMD_REBOOT);
  wire goErase    = wrCode && cmdIdle && (writeData == beam_cmd_pkg::CMD_ERASE);
  wire goSave     = wrCode && cmdIdle && (writeData == beam_cmd_pkg::CMD_SAVE);
  wire goSplit    = wrCode && cmdIdle && (writeData == beam_cmd_pkg::CMD_SPLIT);
  // any other code, including 0, 1 and 7, falls through unused

  // argument fields; count clamps to 1..32 so the walk stays bounded
  wire [7:0] reqCount = cmdParam[`PARAM_COUNT_MSB:0];
  wire [5:0] useCount = (reqCount == 8'h00) ? 6'd1 :
                        (reqCount > 8'd32) ? 6'd32 : reqCount[5:0];

  // ============================================================
  // split walk arithmetic: beam b lands in floor(b * count / beams)
  wire [7:0] walkSum  = walkAcc + {2'b00, areaCount};
  wire       walkWrap = (walkSum >= 8'd64);
  wire       walkEnd  = (walkBeam == 7'd63);
  wire       saveEnd  = saveDone || (saveCount >= SAVE_CYCLES - 1);

  // ============================================================
  // sequencer next state
  always_comb begin
    next_state = state;
    case (state)
      beam_cmd_pkg::ST_IDLE: begin
        if (goSplit) begin
          next_state = beam_cmd_pkg::ST_SPLIT;
        end else if (goSave) begin
          next_state = beam_cmd_pkg::ST_SAVE;
        end
      end
      beam_cmd_pkg::ST_SPLIT: begin
        if (walkEnd) begin
          next_state = beam_cmd_pkg::ST_IDLE;
        end
      end
      beam_cmd_pkg::ST_SAVE: begin
        if (saveEnd) begin
          next_state = beam_cmd_pkg::ST_IDLE;
        end
      end
      default: begin
        next_state = beam_cmd_pkg::ST_IDLE;
      end
    endcase
  end

  // state register and status levels
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state     <= beam_cmd_pkg::ST_IDLE;
      saveBusy  <= 1'b0;
      splitBusy <= 1'b0;
    end else begin
      state     <= next_state;
      saveBusy  <= (next_state == beam_cmd_pkg::ST_SAVE);
      splitBusy <= (next_state == beam_cmd_pkg::ST_SPLIT);
    end
  end

  // ============================================================
  // argument register
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cmdParam <= 16'h0001;
    end else if (wrParam) begin
      cmdParam <= writeData;
    end
  end

  // command pulses, one cycle each
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      teachStart <= 1'b0;
      rebootReq  <= 1'b0;
      eraseReq   <= 1'b0;
      saveStart  <= 1'b0;
    end else begin
      teachStart <= goTeach;
      rebootReq  <= goReboot;
      eraseReq   <= goErase;
      saveStart  <= goSave;
    end
  end

  // save window counter
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      saveCount <= 32'h0000_0000;
    end else if (state == beam_cmd_pkg::ST_SAVE) begin
      saveCount <= saveCount + 32'h0000_0001;
    end else begin
      saveCount <= 32'h0000_0000;
    end
  end

  // ============================================================
  // teach status byte
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      teachStatus  <= `TEACH_OK;
      teachRunning <= 1'b0;
    end else if (goTeach) begin
      teachStatus  <= `TEACH_BUSY;
      teachRunning <= 1'b1;
    end else if (teachRunning && (teachDone || teachFail)) begin
      teachStatus  <= teachFail ? `TEACH_ERROR : `TEACH_OK;
      teachRunning <= 1'b0;
    end
  end

  // ============================================================
  // split walk: rebuild area membership and area objects
  // the walk takes one cycle per beam; measurements during it see a mixed map
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      areaCount <= 6'd1;
      allMode   <= 1'b0;
      walkBeam  <= 7'd0;
      walkAcc   <= 8'h00;
      walkArea  <= 5'd0;
      walkNew   <= 1'b1;
      for (int b = 0; b < `NUM_BEAMS; b++) begin
        areaOfBeam[b] <= 5'd0;
      end
      for (int a = 0; a < `MAX_AREAS; a++) begin
        areaFirst[a] <= (a == 0) ? 7'd1 : 7'd0;
        areaLast[a]  <= (a == 0) ? 7'd64 : 7'd0;
      end
    end else if (goSplit) begin
      areaCount <= useCount;
      allMode   <= cmdParam[`PARAM_MODE_BIT];
      walkBeam  <= 7'd0;
      walkAcc   <= 8'h00;
      walkArea  <= 5'd0;
      walkNew   <= 1'b1;
      // unused areas read back as empty
      for (int a = 0; a < `MAX_AREAS; a++) begin
        areaFirst[a] <= 7'd0;
        areaLast[a]  <= 7'd0;
      end
    end else if (state == beam_cmd_pkg::ST_SPLIT) begin
      areaOfBeam[walkBeam[5:0]] <= walkArea;
      if (walkNew) begin
        areaFirst[walkArea] <= walkBeam + 7'd1;
      end
      areaLast[walkArea] <= walkBeam + 7'd1;
      walkBeam <= walkBeam + 7'd1;
      walkNew  <= walkWrap;
      if (walkWrap) begin
        walkAcc  <= walkSum - 8'd64;
        walkArea <= walkArea + 5'd1;
      end else begin
        walkAcc  <= walkSum;
      end
    end
  end

  // ============================================================
  // beam scan: first/last/total of blocked and clear beams
  logic [15:0] scanFb, scanFc, scanLb, scanLc, scanTb, scanTc;
  logic [31:0] anyBlk;                              // area sees a blocked beam
  logic [31:0] allBlk;                              // every beam in area blocked
  logic [31:0] areaNow;                             // combined area result
  always_comb begin
    scanFb = 16'h0000;
    scanFc = 16'h0000;
    scanLb = 16'h0000;
    scanLc = 16'h0000;
    scanTb = 16'h0000;
    scanTc = 16'h0000;
    anyBlk = 32'h0000_0000;
    allBlk = 32'hffff_ffff;
    for (int b = `NUM_BEAMS - 1; b >= 0; b--) begin
      if (beamBlocked[b]) begin
        scanFb = 16'(b + 1);
      end else begin
        scanFc = 16'(b + 1);
      end
    end
    for (int b = 0; b < `NUM_BEAMS; b++) begin
      if (beamBlocked[b]) begin
        scanLb = 16'(b + 1);
        scanTb = scanTb + 16'h0001;
      end else begin
        scanLc = 16'(b + 1);
        scanTc = scanTc + 16'h0001;
      end
      anyBlk[areaOfBeam[b]] = anyBlk[areaOfBeam[b]] | beamBlocked[b];
      allBlk[areaOfBeam[b]] = allBlk[areaOfBeam[b]] & beamBlocked[b];
    end
    // areas past the count stay inactive
    for (int a = 0; a < `MAX_AREAS; a++) begin
      areaNow[a] = (a < int'(areaCount)) && (allMode ? allBlk[a] : anyBlk[a]);
    end
  end

  // ============================================================
  // latch a measurement
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      firstBlocked <= 16'h0000;
      firstClear   <= 16'h0000;
      lastBlocked  <= 16'h0000;
      lastClear    <= 16'h0000;
      blockedTotal <= 16'h0000;
      clearTotal   <= 16'h0000;
      areaRes      <= 32'h0000_0000;
      levelFirst   <= 16'h0000;
      levelLast    <= 16'h0000;
      cycleNum     <= 12'h000;
      validFlag    <= 1'b0;
      switchOut    <= 4'h0;
    end else if (measStrobe) begin
      firstBlocked <= scanFb;
      firstClear   <= scanFc;
      lastBlocked  <= scanLb;
      lastClear    <= scanLc;
      blockedTotal <= scanTb;
      clearTotal   <= scanTc;
      areaRes      <= areaNow;
      levelFirst   <= levelFirstIn;
      levelLast    <= levelLastIn;
      cycleNum     <= cycleNum + 12'h001;
      validFlag    <= 1'b1;
      switchOut    <= areaNow[3:0];
    end
  end

  // ============================================================
  // event flag: set by status change, cleared by reading the status word
  wire rdStatus = readStrobe && hit(regAddr, `IDX_STATUS, `SUB_NONE);
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      eventFlag <= 1'b0;
    end else if (statusChange) begin
      eventFlag <= 1'b1;
    end else if (rdStatus) begin
      eventFlag <= 1'b0;
    end
  end

  // ============================================================
  // read mux
  wire [15:0] statusWord = {validFlag, eventFlag, 2'b00, cycleNum};
  wire [15:0] ioWord     = {8'h00, digitalIn, switchOut};
  wire [15:0] cfgOff     = regAddr[23:8] - `IDX_AREA_CFG_BASE;
  wire        cfgHit     = (regAddr[23:8] >= `IDX_AREA_CFG_BASE) &&
                           (regAddr[23:8] <= `IDX_AREA_CFG_LAST);
  wire [4:0]  cfgIdx     = cfgOff[4:0];
  logic [15:0] readMux;
  always_comb begin
    readMux = 16'h0000;  // unmapped and write-only read as zero
    if (hit(regAddr, `IDX_TEACH, `SUB_TEACH))                readMux = {8'h00, teachStatus};
    else if (hit(regAddr, `IDX_LEVEL, `SUB_LEVEL_FIRST))     readMux = levelFirst;
    else if (hit(regAddr, `IDX_LEVEL, `SUB_LEVEL_LAST))      readMux = levelLast;
    else if (hit(regAddr, `IDX_FIRST_BLOCKED, `SUB_NONE))    readMux = firstBlocked;
    else if (hit(regAddr, `IDX_FIRST_CLEAR, `SUB_NONE))      readMux = firstClear;
    else if (hit(regAddr, `IDX_LAST_BLOCKED, `SUB_NONE))     readMux = lastBlocked;
    else if (hit(regAddr, `IDX_LAST_CLEAR, `SUB_NONE))       readMux = lastClear;
    else if (hit(regAddr, `IDX_BLOCKED_TOTAL, `SUB_NONE))    readMux = blockedTotal;
    else if (hit(regAddr, `IDX_CLEAR_TOTAL, `SUB_NONE))      readMux = clearTotal;
    else if (hit(regAddr, `IDX_AREA_LOW, `SUB_NONE))         readMux = areaRes[15:0];
    else if (hit(regAddr, `IDX_AREA_HIGH, `SUB_NONE))        readMux = areaRes[31:16];
    else if (hit(regAddr, `IDX_IO_STATE, `SUB_NONE))         readMux = ioWord;
    else if (hit(regAddr, `IDX_STATUS, `SUB_NONE))           readMux = statusWord;
    else if (cfgHit && regAddr[7:0] == `SUB_AREA_FIRST)      readMux = {9'h000, areaFirst[cfgIdx]};
    else if (cfgHit && regAddr[7:0] == `SUB_AREA_LAST)       readMux = {9'h000, areaLast[cfgIdx]};
  end

  // read data register, valid only the cycle after the strobe
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      readData <= 16'h0000;
    end else begin
      readData <= readStrobe ? readMux : 16'h0000;
    end
  end

endmodule : beam_command_process_objects
`default_nettype wire

// file: core/beam_cmd_map.svh
// register map, field positions, result codes and timing counts
`ifndef BEAM_CMD_MAP_SVH
`define BEAM_CMD_MAP_SVH
// ============================================================
// addressing: address = {object index, sub-index}
`define ADDR_W              24
`define IDX_CMD             16'h2200
`define SUB_CMD_CODE        8'h01
`define SUB_CMD_PARAM       8'h02
`define IDX_TEACH           16'h2400
`define SUB_TEACH           8'h01
`define IDX_LEVEL           16'h2404
`define SUB_LEVEL_FIRST     8'h01
`define SUB_LEVEL_LAST      8'h02
`define SUB_NONE            8'h00
`define IDX_FIRST_BLOCKED   16'h2405
`define IDX_FIRST_CLEAR     16'h2406
`define IDX_LAST_BLOCKED    16'h2407
`define IDX_LAST_CLEAR      16'h2408
`define IDX_BLOCKED_TOTAL   16'h2409
`define IDX_CLEAR_TOTAL     16'h240a
`define IDX_AREA_LOW        16'h240d
`define IDX_AREA_HIGH       16'h240e
`define IDX_IO_STATE        16'h240f
`define IDX_STATUS          16'h2411
// per-area config objects, area k at base + k - 1
`define IDX_AREA_CFG_BASE   16'h2170
`define IDX_AREA_CFG_LAST   16'h218f
`define SUB_AREA_FIRST      8'h01
`define SUB_AREA_LAST       8'h02
// ============================================================
// fields
`define PARAM_COUNT_MSB     7
`define PARAM_MODE_BIT      8
`define STAT_CYCLE_MSB      11
`define STAT_EVENT_BIT      14
`define STAT_VALID_BIT      15
`define MAX_AREAS           32
`define NUM_BEAMS           64
// ============================================================
// teach result codes
`define TEACH_OK            8'h00
`define TEACH_BUSY          8'h01
`define TEACH_ERROR         8'h80
// ============================================================
// timing
`define CLK_PERIOD_NS       10
`define SAVE_TIME_MS        600
`define SAVE_CYCLES         ((`SAVE_TIME_MS * 1000000) / `CLK_PERIOD_NS)
`endif

// file: core/beam_cmd_pkg.sv
// types shared by the command and process-data block
package beam_cmd_pkg;
  // ============================================================
  // command codes
  typedef enum logic [15:0] {
    CMD_TEACH  = 16'h0003,
    CMD_REBOOT = 16'h0004,
    CMD_ERASE  = 16'h0005,
    CMD_SAVE   = 16'h0006,
    CMD_SPLIT  = 16'h0008
  } cmd_t;
  // ============================================================
  // sequencer states
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_SPLIT = 2'b01,
    ST_SAVE  = 2'b10
  } state_t;
endpackage : beam_cmd_pkg

// file: tb/beam_cmd_asserts.sv
// concurrent checks on the command block ports
`timescale 1ns/1ps
`default_nettype none
`include "beam_cmd_map.svh"
module beam_cmd_asserts #(
  parameter int unsigned SAVE_CYCLES = 50  // save window in cycles
) (
  input wire logic                ref_clk,
  input wire logic                rst_n,
  input wire logic [`ADDR_W-1:0]  regAddr,
  input wire logic [15:0]         writeData,
  input wire logic                writeStrobe,
  input wire logic                measStrobe,
  input wire logic                teachStart,
  input wire logic                rebootReq,
  input wire logic                eraseReq,
  input wire logic                saveStart,
  input wire logic                saveBusy,
  input wire logic                splitBusy,
  input wire logic [3:0]          switchOut
);
  // window plus exit latency, with slack for the registered flag
  localparam int SAVE_MAX = SAVE_CYCLES + 3;
  // ==========
  // command code decode
  wire codeWr = writeStrobe && (regAddr == {`IDX_CMD, `SUB_CMD_CODE});  // any code write
  wire cmdWr  = codeWr && !saveBusy && !splitBusy;                     // accepted when idle
  wire anyReq = teachStart || rebootReq || eraseReq || saveStart;       // any command pulse
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // ==========
  // command launch
  a_teach_start: assert property (cmdWr && writeData == 16'h0003 |=> teachStart)
    else $error("teach pulse missing");
  a_reboot_start: assert property (cmdWr && writeData == 16'h0004 |=> rebootReq)
    else $error("reboot pulse missing");
  a_erase_start: assert property (cmdWr && writeData == 16'h0005 |=> eraseReq)
    else $error("erase pulse missing");
  a_save_start: assert property (cmdWr && writeData == 16'h0006 |=> saveStart && saveBusy)
    else $error("save did not start");
  a_save_bound: assert property ($rose(saveBusy) |-> ##[1:SAVE_MAX] !saveBusy)
    else $error("save ran too long");
  a_split_walk: assert property (cmdWr && writeData == 16'h0008 |-> ##1 splitBusy ##63 splitBusy
                                 ##1 !splitBusy)
    else $error("split walk length wrong");
  a_reserved_quiet: assert property (cmdWr && (writeData == 16'h0000 || writeData == 16'h0001
                                     || writeData == 16'h0007) |=> !anyReq ##1 !splitBusy)
    else $error("reserved code acted");
  a_save_refuse: assert property (codeWr && saveBusy |=> !(teachStart || rebootReq || eraseReq)
                                  ##1 !splitBusy)
    else $error("command taken while saving");
  a_pulse_once: assert property (teachStart |=> !teachStart)
    else $error("teach pulse too long");
  a_switch_hold: assert property (!measStrobe |=> $stable(switchOut))
    else $error("outputs moved without measurement");
endmodule : beam_cmd_asserts
`default_nettype wire

// file: tb/beam_host_partner.sv
// teach and save engine model behind the command outputs
`timescale 1ns/1ps
`default_nettype none
module beam_host_partner #(
  parameter int TEACH_LAT = 20,  // cycles a teach takes
  parameter int SAVE_LAT  = 10   // cycles a fast save takes
) (
  input  wire logic ref_clk,
  input  wire logic rst_n,
  input  wire logic teachStart,
  input  wire logic saveStart,
  input  wire logic slowMode,   // never answer a save, device must time out
  input  wire logic failNext,   // finish the next teach with an error
  output logic      teachDone,
  output logic      teachFail,
  output logic      saveDone
);
  int tCnt;  // teach cycles left, 0 idle
  int sCnt;  // save cycles left, 0 idle
  // ==========
  // countdowns, one-cycle answers
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tCnt      <= 0;
      sCnt      <= 0;
      teachDone <= 1'b0;
      teachFail <= 1'b0;
      saveDone  <= 1'b0;
    end else begin
      teachDone <= (tCnt == 1) && !failNext;
      teachFail <= (tCnt == 1) && failNext;
      saveDone  <= (sCnt == 1);
      if (teachStart) tCnt <= TEACH_LAT;
      else if (tCnt != 0) tCnt <= tCnt - 1;
      // slow mode keeps the store silent to force the timeout
      if (saveStart && !slowMode) sCnt <= SAVE_LAT;
      else if (sCnt != 0) sCnt <= sCnt - 1;
    end
  end
endmodule : beam_host_partner
`default_nettype wire

// file: tb/tb_beam_command_process_objects.sv
// self-checking bench for the command and process-data block
`timescale 1ns/1ps
`default_nettype none
`include "beam_cmd_map.svh"
module tb_beam_command_process_objects;
  localparam int SAVE_N = 50;  // shortened save window
  logic ref_clk = 1'b0;  // only the clock process drives it
  logic rst_n, writeStrobe, readStrobe, measStrobe, statusChange;
  logic teachDone, teachFail, saveDone, slowMode, failNext;
  logic teachStart, rebootReq, eraseReq, saveStart, saveBusy, splitBusy;
  logic [`ADDR_W-1:0]    regAddr;
  logic [15:0]           writeData, readData, levelFirstIn, levelLastIn;
  logic [`NUM_BEAMS-1:0] beamBlocked;
  logic [3:0]            digitalIn, switchOut;
  int n_fail, compares, nTeach, nReboot, nErase, nSave, nMeas;
  // process-data objects in read order
  logic [15:0] pdIdx [9] = '{`IDX_FIRST_BLOCKED, `IDX_FIRST_CLEAR, `IDX_LAST_BLOCKED,
    `IDX_LAST_CLEAR, `IDX_BLOCKED_TOTAL, `IDX_CLEAR_TOTAL, `IDX_AREA_LOW, `IDX_AREA_HIGH,
    `IDX_IO_STATE};
  logic [15:0] codes [5] = '{16'h0000, 16'h0001, 16'h0007, 16'h0005, 16'h0004};
  always #5 ref_clk = ~ref_clk;
  beam_command_process_objects #(.SAVE_CYCLES(SAVE_N)) dut_u (.ref_clk(ref_clk), .rst_n(rst_n),
    .regAddr(regAddr), .writeData(writeData), .writeStrobe(writeStrobe),
    .readStrobe(readStrobe), .readData(readData), .measStrobe(measStrobe),
    .beamBlocked(beamBlocked), .levelFirstIn(levelFirstIn), .levelLastIn(levelLastIn),
    .digitalIn(digitalIn), .statusChange(statusChange), .teachDone(teachDone),
    .teachFail(teachFail), .saveDone(saveDone), .teachStart(teachStart),
    .rebootReq(rebootReq), .eraseReq(eraseReq), .saveStart(saveStart),
    .saveBusy(saveBusy), .splitBusy(splitBusy), .switchOut(switchOut));
  beam_host_partner host_u (.ref_clk(ref_clk), .rst_n(rst_n), .teachStart(teachStart),
    .saveStart(saveStart), .slowMode(slowMode), .failNext(failNext),
    .teachDone(teachDone), .teachFail(teachFail), .saveDone(saveDone));
  // ==========
  // command pulse tallies
  always @(posedge ref_clk) begin
    if (teachStart === 1'b1) nTeach++;
    if (rebootReq === 1'b1) nReboot++;
    if (eraseReq === 1'b1) nErase++;
    if (saveStart === 1'b1) nSave++;
  end
  task chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task wr(input logic [`ADDR_W-1:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    writeData <= d;
    writeStrobe <= 1'b1;
    @(posedge ref_clk);
    writeStrobe <= 1'b0;
  endtask : wr
  // data stand only in the cycle after the strobe
  task rd(input logic [`ADDR_W-1:0] a, input logic [15:0] e);
    @(posedge ref_clk);
    regAddr <= a;
    readStrobe <= 1'b1;
    @(posedge ref_clk);
    readStrobe <= 1'b0;
    #1 chk(readData, e);
  endtask : rd
  // bounded wait for split or save to finish
  task settle;
    int i;
    i = 0;
    repeat (3) @(posedge ref_clk);
    while ((splitBusy || saveBusy) && i < 200) begin
      @(posedge ref_clk);
      i++;
    end
    chk({15'h0000, splitBusy | saveBusy}, 16'h0000);
  endtask : settle
  task meas(input logic [63:0] b, input logic [15:0] e [9]);
    @(posedge ref_clk);
    beamBlocked <= b;
    measStrobe <= 1'b1;
    @(posedge ref_clk);
    measStrobe <= 1'b0;
    nMeas++;
    for (int k = 0; k < 9; k++) rd({pdIdx[k], `SUB_NONE}, e[k]);
    rd({`IDX_STATUS, `SUB_NONE}, {4'h8, nMeas[11:0]});
  endtask : meas
  task conclude;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : conclude
  // ==========
  // watchdog, far beyond the few hundred cycles the tests need
  initial begin
    #100us;
    n_fail++;
    conclude;
  end
  // ==========
  // main sequence
  initial begin
    {rst_n, writeStrobe, readStrobe, measStrobe, statusChange} = '0;
    {slowMode, failNext, regAddr, writeData, beamBlocked} = '0;
    levelFirstIn = 16'h1234;
    levelLastIn = 16'h5678;
    digitalIn = 4'hA;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    rd({`IDX_TEACH, `SUB_TEACH}, 16'h0000);
    rd({`IDX_AREA_CFG_BASE, `SUB_AREA_LAST}, 16'h0040);
    rd(24'h12_3456, 16'h0000);
    meas(64'h0000_0000_0000_03FC, '{16'h0003, 16'h0001, 16'h000A, 16'h0040, 16'h0008,
      16'h0038, 16'h0001, 16'h0000, 16'h00A1});
    rd({`IDX_LEVEL, `SUB_LEVEL_FIRST}, 16'h1234);
    rd({`IDX_LEVEL, `SUB_LEVEL_LAST}, 16'h5678);
    // all 32 areas: two beams each, last area at the top object
    wr({`IDX_CMD, `SUB_CMD_PARAM}, 16'h0020);
    wr({`IDX_CMD, `SUB_CMD_CODE}, 16'h0008);
    settle;
    rd({`IDX_AREA_CFG_BASE, `SUB_AREA_FIRST}, 16'h0001);
    rd({`IDX_AREA_CFG_LAST, `SUB_AREA_FIRST}, 16'h003F);
    rd({`IDX_AREA_CFG_LAST, `SUB_AREA_LAST}, 16'h0040);
    meas(64'hC000_0000_0000_0000, '{16'h003F, 16'h0001, 16'h0040, 16'h003E, 16'h0002,
      16'h003E, 16'h0000, 16'h8000, 16'h00A0});
    // four areas, all beams needed
    wr({`IDX_CMD, `SUB_CMD_PARAM}, 16'h0104);
    wr({`IDX_CMD, `SUB_CMD_CODE}, 16'h0008);
    settle;
    rd({16'h2171, `SUB_AREA_FIRST}, 16'h0011);
    rd({16'h2171, `SUB_AREA_LAST}, 16'h0020);
    meas(64'h0000_0000_FFFF_0001, '{16'h0001, 16'h0002, 16'h0020, 16'h0040, 16'h0011,
      16'h002F, 16'h0002, 16'h0000, 16'h00A2});
    // event flag, cleared by reading
    @(posedge ref_clk);
    statusChange <= 1'b1;
    @(posedge ref_clk);
    statusChange <= 1'b0;
    rd({`IDX_STATUS, `SUB_NONE}, {4'hC, nMeas[11:0]});
    rd({`IDX_STATUS, `SUB_NONE}, {4'h8, nMeas[11:0]});
    // teach ok, then teach with error
    for (int f = 0; f < 2; f++) begin
      failNext <= f[0];
      wr({`IDX_CMD, `SUB_CMD_CODE}, 16'h0003);
      rd({`IDX_TEACH, `SUB_TEACH}, 16'h0001);
      repeat (30) @(posedge ref_clk);
      rd({`IDX_TEACH, `SUB_TEACH}, f ? 16'h0080 : 16'h0000);
    end
    // reserved codes, then erase followed by reboot
    for (int c = 0; c < 5; c++) begin
      wr({`IDX_CMD, `SUB_CMD_CODE}, codes[c]);
      settle;
    end
    chk(16'(nErase), 16'h0001);
    chk(16'(nReboot), 16'h0001);
    // fast save with a refused teach, then save by timeout
    wr({`IDX_CMD, `SUB_CMD_CODE}, 16'h0006);
    wr({`IDX_CMD, `SUB_CMD_CODE}, 16'h0003);
    settle;
    slowMode <= 1'b1;
    wr({`IDX_CMD, `SUB_CMD_CODE}, 16'h0006);
    settle;
    chk(16'(nSave), 16'h0002);
    chk(16'(nTeach), 16'h0002);
    conclude;
  end
endmodule : tb_beam_command_process_objects
bind beam_command_process_objects beam_cmd_asserts #(.SAVE_CYCLES(SAVE_CYCLES)) chk_u (
  .ref_clk(ref_clk), .rst_n(rst_n), .regAddr(regAddr), .writeData(writeData),
  .writeStrobe(writeStrobe), .measStrobe(measStrobe), .teachStart(teachStart),
  .rebootReq(rebootReq), .eraseReq(eraseReq), .saveStart(saveStart),
  .saveBusy(saveBusy), .splitBusy(splitBusy), .switchOut(switchOut));
`default_nettype wire
